//--- design/adcc_pkg.sv
// adcc_pkg: register map, field positions, reset values and timing counts
// assumes: 8-bit registers on a 32-bit APB word map, pclk at 250 MHz
package adcc_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00;
    localparam logic [7:0] ADDR_INPUT_CLOCK = 8'h04;
    localparam logic [7:0] ADDR_REF_AMP = 8'h08;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h10;
    localparam logic [7:0] ADDR_BANDGAP_CTRL = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CS_START_BIT = 7;
    localparam int CS_BUSY_BIT = 6;
    localparam int CS_ENABLE_BIT = 5;
    localparam int CS_JUSTIFY_BIT = 4;
    localparam int IC_SOURCE_LSB = 4;
    localparam int RA_ENABLE_BIT = 7;
    localparam int RA_INPUT_BIT = 4;
    localparam int RA_VREF_LSB = 2;
    localparam int BG_ENABLE_BIT = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
    localparam logic [7:0] RST_INPUT_CLOCK = 8'h00;
    localparam logic [7:0] RST_REF_AMP = 8'h00;
    localparam logic RST_BANDGAP = 1'b0;
    localparam logic [11:0] RST_RESULT = 12'h000;

    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int RES_W = 12;
    localparam int NUM_CHAN = 8;
    localparam int DIV_CNT_W = 7;
    localparam logic [4:0] CONV_TICKS = 5'h10;
    localparam logic [3:0] RESERVED_CHAN = 4'h2;

    // ------------------------------------------------------------
    // internal source codes driven to the input multiplexer
    // ------------------------------------------------------------
    localparam logic [2:0] INT_NONE = 3'h0;
    localparam logic [2:0] INT_SUPPLY = 3'h1;
    localparam logic [2:0] INT_SUPPLY_HALF = 3'h2;
    localparam logic [2:0] INT_SUPPLY_QUARTER = 3'h3;
    localparam logic [2:0] INT_AMP = 3'h4;
    localparam logic [2:0] INT_AMP_HALF = 3'h5;
    localparam logic [2:0] INT_AMP_QUARTER = 3'h6;
    localparam logic [2:0] INT_NEG_SUPPLY = 3'h7;

    typedef enum logic [0:0] {
        SEQ_IDLE,
        SEQ_CONV
    } adcc_seq_e;

endpackage : adcc_pkg

//--- design/adcc_conv_if.sv
// adcc_conv_if: carrier between register block and conversion sequencer
// assumes: one clock domain, all signals synchronous to pclk
`timescale 1ns/1ns
`default_nettype none
interface adcc_conv_if;
    logic go;
    logic enable;
    logic tick;
    logic [11:0] sample;
    logic busy;
    logic done;
    logic [11:0] result;

    modport ctl (output go, output enable, output tick, output sample,
                 input busy, input done, input result);
    modport seq (input go, input enable, input tick, input sample,
                 output busy, output done, output result);
endinterface : adcc_conv_if
`default_nettype wire

//--- design/adcc_clkdiv.sv
// adcc_clkdiv: conversion clock prescaler, one-cycle tick every 2**div cycles
// assumes: driven from pclk, div taken straight from the clock select field
`timescale 1ns/1ns
`default_nettype none
module adcc_clkdiv
    import adcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [2:0] div,
    output logic tick
);

    logic [DIV_CNT_W-1:0] cnt_q, cnt_d;
    logic tick_q, tick_d;
    logic [DIV_CNT_W-1:0] last;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    always_comb begin
        last = DIV_CNT_W'((8'h01 << div) - 8'h01);
        if (cnt_q >= last) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 7'h01;
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (ce) begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    undiv_tick_a: assert property (ce && div == 3'h0 |=> tick)
        else $error("undivided conversion clock missed a tick");
    max_div_a: assert property (ce && tick && div == 3'h7 && cnt_q == 7'h00
                                |=> (!tick || $past(div) != 3'h7) [*8])
        else $error("divide by 128 ticked too early");

endmodule // adcc_clkdiv
`default_nettype wire

//--- design/adcc_seq.sv
// adcc_seq: conversion sequencer, busy flag and atomic result capture
// assumes: sample is already synchronised to pclk by the register block
`timescale 1ns/1ns
`default_nettype none
module adcc_seq
    import adcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    adcc_conv_if.seq cv
);

    adcc_seq_e state_q, state_d;
    logic [4:0] cnt_q, cnt_d;
    logic done_q, done_d;
    logic [RES_W-1:0] result_q, result_d;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        result_d = result_q;
        case (state_q)
            SEQ_IDLE: begin
                if (cv.go) begin
                    state_d = SEQ_CONV;
                    cnt_d = CONV_TICKS;
                end
            end
            SEQ_CONV: begin
                if (!cv.enable) begin
                    state_d = SEQ_IDLE;
                end else if (cv.tick) begin
                    if (cnt_q == 5'h01) begin
                        state_d = SEQ_IDLE;
                        done_d = 1'b1;
                        result_d = cv.sample;
                    end else begin
                        cnt_d = cnt_q - 5'h01;
                    end
                end
            end
            default: state_d = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SEQ_IDLE;
            cnt_q <= 5'h00;
            done_q <= 1'b0;
            result_q <= RST_RESULT;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            result_q <= result_d;
        end
    end

    assign cv.busy = (state_q == SEQ_CONV);
    assign cv.done = done_q;
    assign cv.result = result_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    atomic_result_a: assert property (ce && cv.busy && cv.enable && cv.tick && cnt_q == 5'h01
                                      |=> !cv.busy && cv.done && cv.result == $past(cv.sample))
        else $error("result and busy did not change together");
    busy_ignore_a: assert property (ce && cv.busy && cv.enable && !cv.tick
                                    |=> cv.busy && cnt_q == $past(cnt_q))
        else $error("running conversion disturbed");

    conv_done_c: cover property (cv.done);
    conv_abort_c: cover property (cv.busy ##1 !cv.busy && !cv.done);

endmodule // adcc_seq
`default_nettype wire

//--- design/adcc_top.sv
// adcc_top: converter control registers, APB slave, input and amplifier steering
// assumes: APB master on pclk; analog core result arrives asynchronously on core_data
//
// Functional notes
// - writing start high then low begins one conversion
// - busy flag reads 1 from start until conversion ends
// - converter enable powers the converter; starts ignored while off
// - results keep their contents while the converter is disabled
// - justify bit chooses left or right alignment across the byte pair
// - result bits not holding data read zero
// - input source field picks external channel or one internal signal
// - channels 0,1,3..7 map by code; code 2 and 8..15 connect nothing
// - internal source selection disconnects every external channel
// - conversion clock is system clock divided by two to the field
// - unimplemented register bits read zero
// - amplifier enable bit switches the reference amplifier
// - bandgap input select disconnects the reference input pin
// - each finished conversion raises the done event
`timescale 1ns/1ns
`default_nettype none
module adcc_top
    import adcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] core_data,
    output logic converter_enable,
    output logic conv_clk_tick,
    output logic conv_busy_flag,
    output logic conv_done,
    output logic [NUM_CHAN-1:0] external_channel_n,
    output logic [2:0] internal_source,
    output logic ref_amp_enable,
    output logic ref_amp_input_select,
    output logic ref_amp_input_pin,
    output logic [1:0] ref_voltage_select,
    output logic [1:0] amp_gain_select,
    output logic bandgap_enable
);

    adcc_conv_if cv ();

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic start_q, start_d;
    logic enable_q, enable_d;
    logic justify_q, justify_d;
    logic [3:0] chan_q, chan_d;
    logic [3:0] source_q, source_d;
    logic [2:0] div_q, div_d;
    logic amp_en_q, amp_en_d;
    logic amp_in_q, amp_in_d;
    logic [1:0] vref_q, vref_d;
    logic [1:0] gain_q, gain_d;
    logic bg_q, bg_d;
    logic go;
    logic start_fall;

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [7:0] rd_byte;
    logic mapped;
    logic wr_xfer;
    logic [7:0] wb;
    logic [RES_W-1:0] res;

    assign res = cv.result;
    assign wb = pwdata[7:0];
    assign wr_xfer = psel && penable && pready_q && pwrite;

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            ADDR_CTRL_STATUS: rd_byte = {start_q, cv.busy, enable_q, justify_q, chan_q};
            ADDR_INPUT_CLOCK: rd_byte = {source_q, 1'b0, div_q};
            ADDR_REF_AMP: rd_byte = {amp_en_q, 2'b00, amp_in_q, vref_q, gain_q};
            ADDR_RESULT_HIGH: rd_byte = justify_q ? {4'h0, res[11:8]} : res[11:4];
            ADDR_RESULT_LOW: rd_byte = justify_q ? res[7:0] : {res[3:0], 4'h0};
            ADDR_BANDGAP_CTRL: rd_byte = {7'h00, bg_q};
            default: begin
                rd_byte = 8'h00;
                mapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        pready_d = psel && penable && !pready_q;
        pslverr_d = psel && penable && !pready_q && !mapped;
        prdata_d = prdata_q;
        if (psel && penable && !pready_q && !pwrite) begin
            prdata_d = {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (ce) begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_comb begin
        start_d = start_q;
        enable_d = enable_q;
        justify_d = justify_q;
        chan_d = chan_q;
        source_d = source_q;
        div_d = div_q;
        amp_en_d = amp_en_q;
        amp_in_d = amp_in_q;
        vref_d = vref_q;
        gain_d = gain_q;
        bg_d = bg_q;
        if (wr_xfer) begin
            case (paddr)
                ADDR_CTRL_STATUS: begin
                    start_d = wb[CS_START_BIT];
                    enable_d = wb[CS_ENABLE_BIT];
                    justify_d = wb[CS_JUSTIFY_BIT];
                    chan_d = wb[3:0];
                end
                ADDR_INPUT_CLOCK: begin
                    source_d = wb[IC_SOURCE_LSB +: 4];
                    div_d = wb[2:0];
                end
                ADDR_REF_AMP: begin
                    amp_en_d = wb[RA_ENABLE_BIT];
                    amp_in_d = wb[RA_INPUT_BIT];
                    vref_d = wb[RA_VREF_LSB +: 2];
                    gain_d = wb[1:0];
                end
                ADDR_BANDGAP_CTRL: bg_d = wb[BG_ENABLE_BIT];
                default: bg_d = bg_q;
            endcase
        end
    end

    // high-then-low on start, converter on, not already running
    assign start_fall = start_q && !start_d;
    assign go = start_fall && enable_q && !cv.busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q <= RST_CTRL_STATUS[CS_START_BIT];
            enable_q <= RST_CTRL_STATUS[CS_ENABLE_BIT];
            justify_q <= RST_CTRL_STATUS[CS_JUSTIFY_BIT];
            chan_q <= RST_CTRL_STATUS[3:0];
            source_q <= RST_INPUT_CLOCK[IC_SOURCE_LSB +: 4];
            div_q <= RST_INPUT_CLOCK[2:0];
            amp_en_q <= RST_REF_AMP[RA_ENABLE_BIT];
            amp_in_q <= RST_REF_AMP[RA_INPUT_BIT];
            vref_q <= RST_REF_AMP[RA_VREF_LSB +: 2];
            gain_q <= RST_REF_AMP[1:0];
            bg_q <= RST_BANDGAP;
        end else if (ce) begin
            start_q <= start_d;
            enable_q <= enable_d;
            justify_q <= justify_d;
            chan_q <= chan_d;
            source_q <= source_d;
            div_q <= div_d;
            amp_en_q <= amp_en_d;
            amp_in_q <= amp_in_d;
            vref_q <= vref_d;
            gain_q <= gain_d;
            bg_q <= bg_d;
        end
    end

    // ------------------------------------------------------------
    // core data synchroniser
    // ------------------------------------------------------------
    logic [RES_W-1:0] data_s1_q, data_s2_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_s1_q <= RST_RESULT;
            data_s2_q <= RST_RESULT;
        end else if (ce) begin
            data_s1_q <= core_data;
            data_s2_q <= data_s1_q;
        end
    end

    // ------------------------------------------------------------
    // sequencer and prescaler
    // ------------------------------------------------------------
    logic tick;

    assign cv.go = go && ce;
    assign cv.enable = enable_q;
    assign cv.tick = tick;
    assign cv.sample = data_s2_q;

    adcc_clkdiv u_clkdiv (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .div(div_q),
        .tick(tick)
    );

    adcc_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .cv(cv)
    );

    // ------------------------------------------------------------
    // analog steering
    // ------------------------------------------------------------
    logic ext_sel;
    logic [2:0] int_d;
    logic [NUM_CHAN-1:0] chan_d_vec;
    logic [NUM_CHAN-1:0] chan_out_q;
    logic [2:0] int_q;
    logic en_out_q, busy_out_q, done_out_q, tick_out_q;
    logic amp_en_out_q, amp_in_out_q, pin_out_q, bg_out_q;
    logic [1:0] vref_out_q, gain_out_q;

    always_comb begin
        ext_sel = 1'b0;
        int_d = INT_NONE;
        case (source_q)
            4'h0, 4'h4, 4'hc, 4'hd, 4'he, 4'hf: ext_sel = 1'b1;
            4'h1: int_d = INT_SUPPLY;
            4'h2: int_d = INT_SUPPLY_HALF;
            4'h3: int_d = INT_SUPPLY_QUARTER;
            4'h5: int_d = INT_AMP;
            4'h6: int_d = INT_AMP_HALF;
            4'h7: int_d = INT_AMP_QUARTER;
            default: int_d = INT_NEG_SUPPLY;
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
            // codes 8..15 and the reserved code reach no channel
            assign chan_d_vec[gi] = ext_sel && enable_q && (chan_q == 4'(gi))
                                    && (4'(gi) != RESERVED_CHAN);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_out_q <= '0;
            int_q <= INT_NONE;
            en_out_q <= 1'b0;
            busy_out_q <= 1'b0;
            done_out_q <= 1'b0;
            tick_out_q <= 1'b0;
            amp_en_out_q <= 1'b0;
            amp_in_out_q <= 1'b0;
            pin_out_q <= 1'b0;
            vref_out_q <= 2'b00;
            gain_out_q <= 2'b00;
            bg_out_q <= 1'b0;
        end else if (ce) begin
            chan_out_q <= chan_d_vec;
            int_q <= int_d;
            en_out_q <= enable_q;
            busy_out_q <= cv.busy;
            done_out_q <= cv.done;
            tick_out_q <= tick && enable_q;
            amp_en_out_q <= amp_en_q;
            amp_in_out_q <= amp_in_q;
            pin_out_q <= amp_en_q && !amp_in_q;
            vref_out_q <= vref_q;
            gain_out_q <= gain_q;
            bg_out_q <= bg_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign converter_enable = en_out_q;
    assign conv_clk_tick = tick_out_q;
    assign conv_busy_flag = busy_out_q;
    assign conv_done = done_out_q;
    assign external_channel_n = chan_out_q;
    assign internal_source = int_q;
    assign ref_amp_enable = amp_en_out_q;
    assign ref_amp_input_select = amp_in_out_q;
    assign ref_amp_input_pin = pin_out_q;
    assign ref_voltage_select = vref_out_q;
    assign amp_gain_select = gain_out_q;
    assign bandgap_enable = bg_out_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    start_busy_a: assert property (cv.go |=> cv.busy ##1 conv_busy_flag)
        else $error("start sequence did not set busy");
    result_hold_a: assert property (!enable_q && !cv.busy |=> $stable(cv.result))
        else $error("result changed while converter off");
    chan_off_a: assert property (ce && !ext_sel |=> external_channel_n == '0)
        else $error("external channel connected with internal source");
    unused_zero_a: assert property (ce && psel && penable && !pready_q && !pwrite && paddr == ADDR_INPUT_CLOCK
                                    |=> prdata[3] == 1'b0 && prdata[31:8] == 24'h000000)
        else $error("unimplemented bit read nonzero");
    justify_zero_a: assert property (ce && psel && penable && !pready_q && !pwrite && justify_q
                                     && paddr == ADDR_RESULT_HIGH |=> prdata[7:4] == 4'h0)
        else $error("unused result bits read nonzero");
    done_event_a: assert property (ce && cv.done |=> conv_done)
        else $error("completion event not raised");
    no_restart_a: assert property (ce && cv.busy && enable_q && start_fall
                                   |=> u_seq.cnt_q <= $past(u_seq.cnt_q))
        else $error("start accepted while busy");
    pin_cut_a: assert property (ce && amp_in_q |=> !ref_amp_input_pin)
        else $error("reference pin left on with bandgap");

    full_conv_c: cover property (cv.go ##[1:300] cv.done);
    busy_start_c: cover property (cv.busy && start_fall);
    read_result_c: cover property (pready && !pwrite && paddr == ADDR_RESULT_LOW);

endmodule // adcc_top
`default_nettype wire

//--- verif/adcc_core_model.sv
// adcc_core_model: analog core stand-in, result code follows the routed input
// assumes: steering outputs of adcc_top, sampled on pclk
`timescale 1ns/1ns
`default_nettype none
module adcc_core_model
    import adcc_pkg::*;
(
    input wire logic pclk,
    input wire logic converter_enable,
    input wire logic [NUM_CHAN-1:0] external_channel_n,
    input wire logic [2:0] internal_source,
    output logic [11:0] core_data
);
    logic [11:0] wander = 12'h000;
    always @(posedge pclk) wander <= wander + 12'h001;
    always_comb begin
        core_data = wander;
        if (internal_source != INT_NONE) core_data = {9'h1c3, internal_source};
        else for (int i = 0; i < NUM_CHAN; i++) if (external_channel_n[i]) core_data = 12'h5a0 | 12'(i);
        if (!converter_enable) core_data = ~wander;
    end
endmodule // adcc_core_model
`default_nettype wire

//--- verif/adcc_top_tb.sv
// adcc_top_tb: apb sequences with expected values
// assumes: adcc_core_model drives core_data
`timescale 1ns/1ns
`default_nettype none
module adcc_top_tb
    import adcc_pkg::*;
;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, last_err, ext;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [11:0] core_data;
    logic converter_enable, conv_clk_tick, conv_busy_flag, conv_done, bandgap_enable;
    logic ref_amp_enable, ref_amp_input_select, ref_amp_input_pin;
    logic [NUM_CHAN-1:0] external_channel_n;
    logic [2:0] internal_source;
    logic [1:0] ref_voltage_select, amp_gain_select;
    logic [3:0] s, c;
    int n_mismatch = 0, checked = 0, cnt = 0, i, k, g, t0;
    wire [7:0] amp_o = {ref_amp_enable, ref_amp_input_select, ref_amp_input_pin,
                        ref_voltage_select, amp_gain_select, bandgap_enable};
    adcc_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_data(core_data), .converter_enable(converter_enable),
        .conv_clk_tick(conv_clk_tick), .conv_busy_flag(conv_busy_flag), .conv_done(conv_done),
        .external_channel_n(external_channel_n), .internal_source(internal_source),
        .ref_amp_enable(ref_amp_enable), .ref_amp_input_select(ref_amp_input_select),
        .ref_amp_input_pin(ref_amp_input_pin), .ref_voltage_select(ref_voltage_select),
        .amp_gain_select(amp_gain_select), .bandgap_enable(bandgap_enable));
    adcc_core_model core (.pclk(pclk), .converter_enable(converter_enable),
        .external_channel_n(external_channel_n), .internal_source(internal_source),
        .core_data(core_data));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) cnt <= cnt + 1;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [2:0] src_exp(input logic [3:0] v);
        case (v)
            4'h1, 4'h2, 4'h3: return v[2:0];
            4'h5, 4'h6, 4'h7: return v[2:0] - 3'h1;
            4'h8, 4'h9, 4'ha, 4'hb: return 3'h7;
            default: return 3'h0;
        endcase
    endfunction
    task automatic tally_and_finish();
        $display("mismatches %0d of %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one idle edge first, so a release never meets the next setup
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rdat, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (conv_done !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        if (conv_done !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic count_done(input int n, output int m);
        m = 0;
        repeat (n) begin
            @(posedge pclk);
            if (conv_done === 1'b1) m++;
        end
    endtask
    task automatic tick_gap(output int m);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (conv_clk_tick !== 1'b1 && n < 300);
        m = 0;
        do begin
            @(posedge pclk);
            m++;
        end while (conv_clk_tick !== 1'b1 && m < 300);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 7; i++) begin
            rd(8'(i * 4), 32'h0, "reset value");
            chk("slverr", 32'(last_err), 32'(i == 6));
        end
        wr(8'h04, 32'hff);
        rd(8'h04, 32'hf7, "input clock");
        wr(8'h14, 32'h01);
        wr(8'h08, 32'hff);
        rd(8'h08, 32'h9f, "amp control");
        cyc(2);
        chk("amp outputs", 32'(amp_o), 32'hdf);
        wr(8'h08, 32'h80);
        cyc(2);
        chk("amp outputs", 32'(amp_o), 32'ha1);
        for (i = 0; i < 32; i++) begin
            s = (i < 16) ? 4'(i) : 4'h0;
            c = (i < 16) ? 4'h5 : 4'(i - 16);
            wr(8'h04, {24'h0, s, 4'h0});
            wr(8'h00, {24'h0, 4'h2, c});
            cyc(2);
            ext = (s == 4'h0) || (s == 4'h4) || (s[3:2] == 2'b11);
            chk("source", 32'(internal_source), 32'(src_exp(s)));
            chk("channel", 32'(external_channel_n), (ext && c < 8 && c != 2) ? 32'h1 << c : 32'h0);
        end
        wr(8'h04, 32'h02);
        wr(8'h00, 32'ha5);
        wr(8'h00, 32'h25);
        t0 = cnt;
        rd(8'h00, 32'h65, "busy set");
        cyc(20);
        wr(8'h00, 32'ha5);
        wr(8'h00, 32'h25);
        wait_done();
        chk("conv time", 32'((cnt - t0) inside {[56:72]}), 32'h1);
        chk("busy out", 32'(conv_busy_flag), 32'h0);
        rd(8'h0c, 32'h5a, "result high");
        rd(8'h10, 32'h50, "result low");
        rd(8'h00, 32'h25, "busy clear");
        wr(8'h00, 32'h35);
        rd(8'h0c, 32'h05, "result high");
        rd(8'h10, 32'ha5, "result low");
        count_done(300, k);
        chk("done count", 32'(k), 32'h0);
        for (i = 0; i < 8; i++) begin
            wr(8'h04, 32'(i));
            tick_gap(g);
            tick_gap(g);
            chk("tick gap", 32'(g), 32'h1 << i);
        end
        wr(8'h04, 32'h70);
        wr(8'h00, 32'hb5);
        wr(8'h00, 32'h35);
        wr(8'h00, 32'h15);
        count_done(100, k);
        chk("abort done", 32'(k), 32'h0);
        chk("enable out", 32'(converter_enable), 32'h0);
        rd(8'h10, 32'ha5, "kept low");
        wr(8'h00, 32'h95);
        wr(8'h00, 32'h15);
        rd(8'h00, 32'h15, "idle when off");
        wr(8'h00, 32'hb5);
        wr(8'h00, 32'h35);
        wait_done();
        rd(8'h0c, 32'h0e, "amp result high");
        rd(8'h10, 32'h1e, "amp result low");
        tally_and_finish();
    end
endmodule // adcc_top_tb
`default_nettype wire
